// ---- hdl/ldot_defs.vh ----
// Constants for the legacy disk instruction translator
`ifndef LDOT_DEFS_VH
`define LDOT_DEFS_VH
// Register byte offsets, then reg_addr[7:6] selects for the unit-map and stored-cylinder banks
`define LDOT_A_CMD      8'h00
`define LDOT_A_DCF      8'h04
`define LDOT_A_DIFF     8'h08
`define LDOT_A_SRCLEN   8'h0C
`define LDOT_A_STATUS   8'h10
`define LDOT_A_RDBACK   8'h14
`define LDOT_A_MAP_SEL  2'h1
`define LDOT_A_CYL_SEL  2'h2
// Command register fields
`define LDOT_F_START    7
`define LDOT_F_WRITE    6
`define LDOT_F_DIRECT   5
`define LDOT_F_MOVE     4
// Mode digits
`define LDOT_M_SEEK     4'h0
`define LDOT_M_TRACK    4'h2
`define LDOT_M_RBC      4'h3
`define LDOT_M_UNUSED   4'h4
`define LDOT_M_SCAN_LO  4'h7
`define LDOT_M_LAST     4'h9
// Channel command codes
`define LDOT_C_SEEK     8'h07
`define LDOT_C_RECAL    8'h13
`define LDOT_C_SEARCH   8'h31
`define LDOT_C_WRITE    8'h05
`define LDOT_C_READ     8'h06
// Data field figures
`define LDOT_BLANK      8'h40
`define LDOT_LEN_SECTOR 12'h064
`define LDOT_LEN_TRACK  12'hBA4
`define LDOT_LOAD_LIMIT 12'h05A
`define LDOT_MAX_CYL    7'h63
// Reset values
`define LDOT_RST_UNIT   8'h00
`define LDOT_RST_CYL    7'h00
`endif

// ---- hdl/ldot_translator.v ----
// Legacy disk instruction translator toward a disk file control unit
// Notes on behaviour
// - Home address is flag, cyl, cyl, head, head; leading cyl and head bytes zero.
// - Record-zero data field is ignored in compatibility mode.
// - Count field declares 100 bytes for sector mode, 2980 for track mode.
// - Load-mode write stops after byte 90, short records padded with 0x40.
// - Move-mode write pads short records with 0x40 to 100 or 2980 bytes.
// - Record number plus one going to disk, minus one coming back.
// - Head number on disk equals the control field head value.
// - Cylinder number on disk is control field cylinder plus one.
// - No module number is recorded on the pack.
// - Data bytes pass unchanged as EBCDIC into the addressed record.
// - Mode digit: 0 seek, 1 sector, 2 track, 3 check, 4 unused, 5-9 others.
// - Home seek: full seek command then six-byte bin,bin,cyl,cyl,head,head address.
// - Direct seek adds signed difference to stored drive cylinder.
// - Seek updates stored cylinder only while control unit is not busy; stored-cylinder register writes land only while translator is idle.
// - Miss, seek, miss without wrong length starts a recalibrate chain.
// - Ten unit-map bytes and five seek-control bytes are held locally.
// - Record zero carries the physical address except on alternate tracks.
// - Cylinder read back from disk is decremented by one.
// - Recalibrate chain ends with a home seek.
`include "ldot_defs.vh"
module ldot_translator #(
  parameter MAP_N = 10,
  parameter DRV_N = 5
) (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst_n,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output wire [31:0] reg_rdata,
  // Source record bytes
  input  wire [7:0]  src_byte,
  input  wire        src_valid,
  output wire        src_ready,
  // Channel toward file control unit
  output wire [7:0]  ch_data,
  output wire        ch_cmd,
  output wire        ch_valid,
  input  wire        ch_ready,
  output wire [7:0]  ch_unit,
  input  wire        cu_busy,
  // Operation outcome and read-back
  input  wire        op_end,
  input  wire        op_nac,
  input  wire        wrong_length_indicator,
  input  wire        rb_valid,
  input  wire [4:0]  rb_record,
  input  wire [6:0]  rb_cyl,
  // Status
  output wire        busy
);

  localparam S_IDLE  = 4'h0;
  localparam S_WAIT  = 4'h1;
  localparam S_RECAL = 4'h2;
  localparam S_SKCMD = 4'h3;
  localparam S_SKADR = 4'h4;
  localparam S_SRCMD = 4'h5;
  localparam S_SRADR = 4'h6;
  localparam S_RWCMD = 4'h7;
  localparam S_CNT   = 4'h8;
  localparam S_DAT   = 4'h9;

  reg  [7:0]  map_q [0:MAP_N-1];
  reg  [6:0]  cyl_st_q [0:DRV_N-1];
  reg  [3:0]  mode_q;
  reg         move_q;
  reg         direct_q;
  reg         write_q;
  reg  [6:0]  dcf_cyl_q;
  reg  [3:0]  dcf_head_q;
  reg  [4:0]  dcf_rec_q;
  reg  [3:0]  dcf_mod_q;
  reg  [7:0]  diff_q;
  reg  [11:0] srclen_q;
  reg         bad_q;
  reg         alt_q;
  reg  [4:0]  rb_rec_q;
  reg  [6:0]  rb_cyl_q;
  reg  [3:0]  st_q;
  reg  [11:0] idx_q;
  reg  [6:0]  tgt_q;
  reg  [1:0]  rc_q;
  reg         recal_q;
  reg         ov_q;
  reg  [7:0]  od_q;
  reg         oc_q;
  reg  [7:0]  unit_q;
  reg  [31:0] rdata_q;
  reg         put_v;
  reg  [7:0]  put_d;
  reg         put_c;
  reg  [7:0]  id_b;
  reg  [31:0] rd_val;
  integer     i;

  wire [2:0]  drive   = dcf_mod_q[3:1];
  wire [3:0]  w_mode  = reg_wdata[3:0];
  wire [3:0]  w_mod   = reg_wdata[27:24];
  wire        start   = reg_wr && (reg_addr == `LDOT_A_CMD) && reg_wdata[`LDOT_F_START];
  wire        mode_ok = (w_mode != `LDOT_M_UNUSED) && (w_mode <= `LDOT_M_LAST) && (dcf_mod_q <= 4'h9);
  wire        emit    = !ov_q || ch_ready;
  wire        track   = (mode_q == `LDOT_M_TRACK);
  wire        rd_only = (mode_q == `LDOT_M_RBC) || (mode_q >= `LDOT_M_SCAN_LO);
  wire [11:0] dlen    = track ? `LDOT_LEN_TRACK : `LDOT_LEN_SECTOR;
  wire [11:0] limit   = move_q ? dlen : `LDOT_LOAD_LIMIT;
  wire [7:0]  disk_cyl = {1'b0, tgt_q} + 8'h01;
  wire [7:0]  disk_rec = {3'h0, dcf_rec_q} + 8'h01;
  wire [8:0]  cur9    = {2'h0, cyl_st_q[drive]};
  wire [8:0]  mag9    = {2'h0, diff_q[6:0]};
  wire [8:0]  sum9    = diff_q[7] ? cur9 - mag9 : cur9 + mag9;
  wire [6:0]  sum_cyl = sum9[8] ? 7'h00 : (sum9 > {2'h0, `LDOT_MAX_CYL}) ? `LDOT_MAX_CYL : sum9[6:0];
  wire        have_src = idx_q < srclen_q;
  wire        dat_go  = (st_q == S_DAT) && emit && (!have_src || src_valid);
  wire        seek_done = (st_q == S_SKADR) && emit && (idx_q == 12'h005);
  wire        miss    = op_end && op_nac && !wrong_length_indicator;
  wire        launch  = (st_q == S_IDLE) && recal_q;

  assign src_ready = (st_q == S_DAT) && emit && have_src;
  assign ch_data   = od_q;
  assign ch_cmd    = oc_q;
  assign ch_valid  = ov_q;
  assign ch_unit   = unit_q;
  assign reg_rdata = rdata_q;
  assign busy      = (st_q != S_IDLE) || ov_q;

  // Identifier bytes: cyl hi, cyl, head hi, head, record
  always @*
  begin
    case (idx_q[2:0])
      3'h0:    id_b = 8'h00;
      3'h1:    id_b = disk_cyl;
      3'h2:    id_b = 8'h00;
      3'h3:    id_b = {4'h0, dcf_head_q};
      3'h4:    id_b = disk_rec;
      3'h5:    id_b = 8'h00;
      3'h6:    id_b = {4'h0, dlen[11:8]};
      default: id_b = dlen[7:0];
    endcase
  end

  // Byte offered to the channel in this cycle
  always @*
  begin
    put_v = 1'b0;
    put_d = 8'h00;
    put_c = 1'b0;
    case (st_q)
      S_RECAL:
      begin
        put_v = emit;
        put_d = `LDOT_C_RECAL;
        put_c = 1'b1;
      end
      S_SKCMD:
      begin
        put_v = emit;
        put_d = `LDOT_C_SEEK;
        put_c = 1'b1;
      end
      S_SKADR:
      begin
        put_v = emit;
        case (idx_q[2:0])
          3'h3:    put_d = disk_cyl;
          3'h5:    put_d = {4'h0, dcf_head_q};
          default: put_d = 8'h00;
        endcase
      end
      S_SRCMD:
      begin
        put_v = emit;
        put_d = `LDOT_C_SEARCH;
        put_c = 1'b1;
      end
      S_SRADR, S_CNT:
      begin
        put_v = emit;
        put_d = id_b;
      end
      S_RWCMD:
      begin
        put_v = emit;
        put_d = (write_q && !rd_only) ? `LDOT_C_WRITE : `LDOT_C_READ;
        put_c = 1'b1;
      end
      S_DAT:
      begin
        put_v = dat_go;
        put_d = have_src ? src_byte : `LDOT_BLANK;
      end
      default:
      begin
        put_v = 1'b0;
      end
    endcase
  end

  // Register read mux
  always @*
  begin
    rd_val = 32'h00000000;
    if (reg_addr[7:6] == `LDOT_A_MAP_SEL)
    begin
      if (reg_addr[5:2] < MAP_N)
        rd_val = {24'h000000, map_q[reg_addr[5:2]]};
    end
    else if (reg_addr[7:6] == `LDOT_A_CYL_SEL)
    begin
      if (reg_addr[4:2] < DRV_N && reg_addr[5] == 1'b0)
        rd_val = {25'h0000000, cyl_st_q[reg_addr[4:2]]};
    end
    else
    begin
      case (reg_addr)
        `LDOT_A_CMD:    rd_val = {24'h000000, 1'b0, write_q, direct_q, move_q, mode_q};
        `LDOT_A_DCF:    rd_val = {4'h0, dcf_mod_q, 3'h0, dcf_rec_q, 4'h0, dcf_head_q, 1'b0, dcf_cyl_q};
        `LDOT_A_DIFF:   rd_val = {24'h000000, diff_q};
        `LDOT_A_SRCLEN: rd_val = {20'h00000, srclen_q};
        `LDOT_A_STATUS: rd_val = {17'h00000, tgt_q, st_q, alt_q, recal_q, bad_q, busy};
        `LDOT_A_RDBACK: rd_val = {17'h00000, rb_cyl_q, 3'h0, rb_rec_q};
        default:        rd_val = 32'h00000000;
      endcase
    end
  end

  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      for (i = 0; i < MAP_N; i = i + 1)
        map_q[i] <= `LDOT_RST_UNIT;
      for (i = 0; i < DRV_N; i = i + 1)
        cyl_st_q[i] <= `LDOT_RST_CYL;
      mode_q     <= 4'h0;
      move_q     <= 1'b0;
      direct_q   <= 1'b0;
      write_q    <= 1'b0;
      dcf_cyl_q  <= 7'h00;
      dcf_head_q <= 4'h0;
      dcf_rec_q  <= 5'h00;
      dcf_mod_q  <= 4'h0;
      diff_q     <= 8'h00;
      srclen_q   <= 12'h000;
      bad_q      <= 1'b0;
      alt_q      <= 1'b0;
      rb_rec_q   <= 5'h00;
      rb_cyl_q   <= 7'h00;
      st_q       <= S_IDLE;
      idx_q      <= 12'h000;
      tgt_q      <= 7'h00;
      rc_q       <= 2'h0;
      recal_q    <= 1'b0;
      ov_q       <= 1'b0;
      od_q       <= 8'h00;
      oc_q       <= 1'b0;
      unit_q     <= 8'h00;
      rdata_q    <= 32'h00000000;
    end
    else
    begin
      rdata_q <= reg_rd ? rd_val : 32'h00000000;
      // Register writes
      if (reg_wr)
      begin
        if (reg_addr[7:6] == `LDOT_A_MAP_SEL && reg_addr[5:2] < MAP_N)
          map_q[reg_addr[5:2]] <= reg_wdata[7:0];
        if (reg_addr[7:6] == `LDOT_A_CYL_SEL && reg_addr[5] == 1'b0 && reg_addr[4:2] < DRV_N && !busy)
          cyl_st_q[reg_addr[4:2]] <= reg_wdata[6:0];
        if (reg_addr == `LDOT_A_DCF)
        begin
          dcf_cyl_q  <= reg_wdata[6:0];
          dcf_head_q <= reg_wdata[11:8];
          dcf_rec_q  <= reg_wdata[20:16];
          dcf_mod_q  <= w_mod;
        end
        if (reg_addr == `LDOT_A_DIFF)
          diff_q <= reg_wdata[7:0];
        if (reg_addr == `LDOT_A_SRCLEN)
          srclen_q <= reg_wdata[11:0];
      end
      // Output byte holding stage
      if (put_v)
      begin
        ov_q <= 1'b1;
        od_q <= put_d;
        oc_q <= put_c;
      end
      else if (ch_ready)
        ov_q <= 1'b0;
      // Recalibrate detector
      if (miss)
      begin
        if (rc_q == 2'h2)
          rc_q <= 2'h0;
        else
          rc_q <= 2'h1;
      end
      else if (op_end)
        rc_q <= 2'h0;
      else if (seek_done && rc_q == 2'h1)
        rc_q <= 2'h2;
      recal_q <= (recal_q && !launch) || (miss && rc_q == 2'h2);
      // Sequencer
      case (st_q)
        S_IDLE:
        begin
          if (launch)
          begin
            direct_q <= 1'b0;
            st_q     <= S_RECAL;
          end
          else if (start)
          begin
            bad_q <= !mode_ok;
            if (mode_ok)
            begin
              alt_q    <= 1'b0;
              mode_q   <= w_mode;
              move_q   <= reg_wdata[`LDOT_F_MOVE];
              direct_q <= reg_wdata[`LDOT_F_DIRECT];
              write_q  <= reg_wdata[`LDOT_F_WRITE];
              unit_q   <= map_q[dcf_mod_q];
              tgt_q    <= dcf_cyl_q;
              st_q     <= (w_mode == `LDOT_M_SEEK) ? S_WAIT : S_SRCMD;
            end
          end
        end
        S_RECAL:
        begin
          if (emit)
            st_q <= S_WAIT;
        end
        S_WAIT:
        begin
          if (!cu_busy)
          begin
            tgt_q           <= direct_q ? sum_cyl : dcf_cyl_q;
            cyl_st_q[drive] <= direct_q ? sum_cyl : dcf_cyl_q;
            st_q            <= S_SKCMD;
          end
        end
        S_SKCMD:
        begin
          if (emit)
          begin
            idx_q <= 12'h000;
            st_q  <= S_SKADR;
          end
        end
        S_SKADR:
        begin
          if (emit)
          begin
            idx_q <= idx_q + 12'h001;
            if (idx_q == 12'h005)
              st_q <= S_IDLE;
          end
        end
        S_SRCMD:
        begin
          if (emit)
          begin
            idx_q <= 12'h000;
            st_q  <= S_SRADR;
          end
        end
        S_SRADR:
        begin
          if (emit)
          begin
            idx_q <= idx_q + 12'h001;
            if (idx_q == 12'h004)
              st_q <= S_RWCMD;
          end
        end
        S_RWCMD:
        begin
          if (emit)
          begin
            idx_q <= 12'h000;
            if (write_q && !rd_only)
              st_q <= S_CNT;
            else
              st_q <= S_IDLE;
          end
        end
        S_CNT:
        begin
          if (emit)
          begin
            if (idx_q == 12'h007)
            begin
              idx_q <= 12'h000;
              st_q  <= S_DAT;
            end
            else
              idx_q <= idx_q + 12'h001;
          end
        end
        S_DAT:
        begin
          if (dat_go)
          begin
            idx_q <= idx_q + 12'h001;
            if (idx_q == limit - 12'h001)
              st_q <= S_IDLE;
          end
        end
        default:
        begin
          st_q <= S_IDLE;
        end
      endcase
      // Read-back conversion, after the sequencer so a set beats a clear at start
      if (rb_valid)
      begin
        if (rb_record != 5'h00)
        begin
          rb_rec_q <= rb_record - 5'h01;
          rb_cyl_q <= rb_cyl - 7'h01;
        end
        else if (rb_cyl != disk_cyl[6:0])
          alt_q <= 1'b1;
      end
    end
  end

endmodule // ldot_translator

// ---- verification/ldot_props.sv ----
// Port checker for the disk instruction translator
`include "ldot_defs.vh"
module ldot_props (
  // Clock and reset
  input wire        ref_clk,
  input wire        rst_n,
  // Register port
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  // Source bytes
  input wire [7:0]  src_byte,
  input wire        src_valid,
  input wire        src_ready,
  // Channel and status
  input wire [7:0]  ch_data,
  input wire        ch_cmd,
  input wire        ch_valid,
  input wire        ch_ready,
  input wire [7:0]  ch_unit,
  input wire        busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] run_q;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // Bytes accepted since the last command byte
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || (ch_valid && ch_cmd))
      run_q <= 12'h000;
    else if (ch_valid && ch_ready)
      run_q <= run_q + 12'h001;
  end
  a_rdata_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside answer cycle");
  a_hold_byte: assert property (ch_valid && !ch_ready |=> ch_valid && $stable(ch_data) && $stable(ch_cmd))
    else $error("channel byte changed before acceptance");
  a_cmd_known: assert property (ch_valid && ch_cmd |-> ch_data inside {`LDOT_C_SEEK, `LDOT_C_RECAL,
    `LDOT_C_SEARCH, `LDOT_C_WRITE, `LDOT_C_READ}) else $error("unknown command code");
  a_valid_busy: assert property (!busy |=> !ch_valid)
    else $error("channel byte straight out of idle");
  a_src_busy: assert property (src_ready |-> busy)
    else $error("source byte taken while idle");
  a_unit_hold: assert property (ch_valid && $past(ch_valid) |-> $stable(ch_unit))
    else $error("unit address changed in a transfer");
  a_run_max: assert property (run_q <= 12'hBAC)
    else $error("too many bytes after a command");
  a_src_pass: assert property (src_valid && src_ready |=> ch_valid && !ch_cmd && ch_data == $past(src_byte))
    else $error("source byte not passed unchanged");
endmodule // ldot_props
bind ldot_translator ldot_props u_props (.ref_clk(ref_clk), .rst_n(rst_n), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .src_byte(src_byte), .src_valid(src_valid), .src_ready(src_ready),
  .ch_data(ch_data), .ch_cmd(ch_cmd), .ch_valid(ch_valid), .ch_ready(ch_ready), .ch_unit(ch_unit),
  .busy(busy));

// ---- verification/ldot_cu_model.sv ----
// File control unit model that accepts and logs channel bytes
module ldot_cu_model (
  // Clock and reset
  input wire         ref_clk,
  input wire         rst_n,
  // Channel from translator
  input wire [7:0]   ch_data,
  input wire         ch_cmd,
  input wire         ch_valid,
  output logic       ch_ready = 1'b1,
  // Pace control
  input wire         slow
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0]  lg[$];
  logic [11:0] wdat_q = 12'h000;
  logic [3:0]  zero_fill;
  // Accept every cycle, or every other cycle when slow
  always @(posedge ref_clk)
  begin
    ch_ready <= !rst_n || !slow || !ch_ready;
    if (rst_n && ch_valid && ch_ready)
    begin
      lg.push_back({ch_cmd, ch_data});
      wdat_q <= ch_cmd ? 12'h000 : wdat_q + 12'h001;
    end
  end
  // Tail bytes left as zeros after a load write
  assign zero_fill = (wdat_q == 12'h062) ? 4'hA : 4'h0;
endmodule // ldot_cu_model

// ---- verification/tb_legacy_disk_op_translator.sv ----
// Self-checking bench for the disk instruction translator
`include "ldot_defs.vh"
module tb_legacy_disk_op_translator;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  src_byte = 8'hC1;
  logic        src_valid = 1'b1;
  logic        cu_busy = 1'b0;
  logic        op_end = 1'b0;
  logic        op_nac = 1'b0;
  logic        wrong_length_indicator = 1'b0;
  logic        rb_valid = 1'b0;
  logic [4:0]  rb_record = 5'h00;
  logic [6:0]  rb_cyl = 7'h00;
  logic        slow = 1'b0;
  logic [31:0] rv;
  logic [8:0]  q[$];
  wire  [31:0] reg_rdata;
  wire  [7:0]  ch_data;
  wire  [7:0]  ch_unit;
  wire         src_ready, ch_cmd, ch_valid, ch_ready, busy;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          i, k, n;
  always #2 ref_clk = ~ref_clk;
  ldot_translator dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_byte(src_byte), .src_valid(src_valid),
    .src_ready(src_ready), .ch_data(ch_data), .ch_cmd(ch_cmd), .ch_valid(ch_valid), .ch_ready(ch_ready),
    .ch_unit(ch_unit), .cu_busy(cu_busy), .op_end(op_end), .op_nac(op_nac),
    .wrong_length_indicator(wrong_length_indicator), .rb_valid(rb_valid), .rb_record(rb_record),
    .rb_cyl(rb_cyl), .busy(busy));
  ldot_cu_model cu (.ref_clk(ref_clk), .rst_n(rst_n), .ch_data(ch_data), .ch_cmd(ch_cmd),
    .ch_valid(ch_valid), .ch_ready(ch_ready), .slow(slow));
  task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task automatic pulse(input logic nac, input logic wl);
    @(posedge ref_clk);
    op_nac <= nac;
    wrong_length_indicator <= wl;
    op_end <= 1'b1;
    @(posedge ref_clk);
    op_end <= 1'b0;
  endtask
  task automatic e(input logic c, input logic [7:0] b);
    q.push_back({c, b});
  endtask
  // Zero, cylinder plus one, zero, head
  task automatic eid(input logic [6:0] c, input logic [3:0] h);
    e(1'b0, 8'h00);
    e(1'b0, {1'b0, c} + 8'h01);
    e(1'b0, 8'h00);
    e(1'b0, {4'h0, h});
  endtask
  task automatic sk(input logic [6:0] c, input logic [3:0] h);
    e(1'b1, `LDOT_C_SEEK);
    e(1'b0, 8'h00);
    e(1'b0, 8'h00);
    eid(c, h);
  endtask
  task automatic srch(input logic [6:0] c, input logic [3:0] h, input logic [4:0] r);
    e(1'b1, `LDOT_C_SEARCH);
    eid(c, h);
    e(1'b0, {3'h0, r} + 8'h01);
  endtask
  // Write command, count field, then source bytes padded with blanks
  task automatic wh(input logic [11:0] len, input int s, input int t);
    e(1'b1, `LDOT_C_WRITE);
    eid(7'h09, 4'h2);
    e(1'b0, 8'h05);
    e(1'b0, 8'h00);
    e(1'b0, {4'h0, len[11:8]});
    e(1'b0, len[7:0]);
    for (int j = 0; j < t; j++)
      e(1'b0, (j < s) ? src_byte : `LDOT_BLANK);
  endtask
  task automatic idle();
    for (i = 0; i < 8 && busy !== 1'b1; i++)
    begin
      @(posedge ref_clk);
      #1;
    end
    for (i = 0; i < 9000 && busy !== 1'b0; i++)
    begin
      @(posedge ref_clk);
      #1;
    end
  endtask
  task automatic go(input logic [31:0] c);
    cu.lg.delete();
    wr(`LDOT_A_CMD, c);
    idle();
  endtask
  task automatic cmp();
    chk("byte count", cu.lg.size(), q.size());
    foreach (q[j])
      if (j < cu.lg.size())
        chk("channel byte", {23'h0, cu.lg[j]}, {23'h0, q[j]});
    q.delete();
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    error_cnt++;
    finish_test();
  end
  initial
  begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(`LDOT_A_STATUS);
    chk("status", rv, 32'h0000_0000);
    wr(8'h40, 32'h0000_002A);
    rd(8'h40);
    chk("unit map", rv, 32'h0000_002A);
    rd(8'hFC);
    chk("unmapped", rv, 32'h0000_0000);
    wr(`LDOT_A_DCF, 32'h0000_0305);
    sk(7'h05, 4'h3);
    go(32'h0000_0080);
    cmp();
    chk("unit", ch_unit, 8'h2A);
    // Direct seek held off by a busy control unit
    wr(8'h80, 32'h0000_000A);
    wr(`LDOT_A_DIFF, 32'h0000_0083);
    cu_busy <= 1'b1;
    slow <= 1'b1;
    cu.lg.delete();
    wr(`LDOT_A_CMD, 32'h0000_00A0);
    repeat (20) @(posedge ref_clk);
    chk("held seek", cu.lg.size(), 0);
    wr(8'h80, 32'h0000_0033);
    rd(8'h80);
    chk("stored cyl", rv, 32'h0000_000A);
    cu_busy <= 1'b0;
    sk(7'h07, 4'h3);
    idle();
    cmp();
    rd(8'h80);
    chk("stored cyl", rv, 32'h0000_0007);
    wr(`LDOT_A_DIFF, 32'h0000_0078);
    sk(7'h63, 4'h3);
    go(32'h0000_00A0);
    cmp();
    // Load write, three source bytes
    wr(`LDOT_A_DCF, 32'h0004_0209);
    wr(`LDOT_A_SRCLEN, 32'h0000_0003);
    srch(7'h09, 4'h2, 5'h04);
    wh(`LDOT_LEN_SECTOR, 3, 90);
    go(32'h0000_00C1);
    cmp();
    chk("zero fill", cu.zero_fill, 32'h0000_000A);
    // Mode digits 1 to 9 and invalid digit 10 in move mode
    wr(`LDOT_A_SRCLEN, 32'h0000_0002);
    for (k = 1; k < 11; k++)
    begin
      n = (k == 2) ? 2980 : 100;
      if (k != 4 && k != 10)
        srch(7'h09, 4'h2, 5'h04);
      if (k == 3 || (k > 6 && k < 10))
        e(1'b1, `LDOT_C_READ);
      else if (k != 4 && k != 10)
        wh(n[11:0], 2, n);
      go(32'h0000_00D0 | k);
      cmp();
      rd(`LDOT_A_STATUS);
      chk("bad mode", rv[1], k == 4 || k == 10);
    end
    // Miss, seek, wrong-length miss: no recalibrate; miss, seek, miss: recalibrate then home seek
    slow <= 1'b0;
    wr(`LDOT_A_DCF, 32'h0000_0305);
    pulse(1'b1, 1'b0);
    go(32'h0000_0080);
    q.delete();
    cu.lg.delete();
    pulse(1'b1, 1'b1);
    idle();
    chk("no recal", cu.lg.size(), 0);
    pulse(1'b1, 1'b0);
    go(32'h0000_0080);
    q.delete();
    cu.lg.delete();
    pulse(1'b1, 1'b0);
    e(1'b1, `LDOT_C_RECAL);
    sk(7'h05, 4'h3);
    idle();
    cmp();
    // Count fields read back from disk
    @(posedge ref_clk);
    rb_record <= 5'h05;
    rb_cyl <= 7'h08;
    rb_valid <= 1'b1;
    @(posedge ref_clk);
    rb_record <= 5'h00;
    rb_cyl <= 7'h7F;
    @(posedge ref_clk);
    rb_valid <= 1'b0;
    rd(`LDOT_A_RDBACK);
    chk("read back", rv, 32'h0000_0704);
    rd(`LDOT_A_STATUS);
    chk("alt track", rv[3], 1'b1);
    finish_test();
  end
endmodule // tb_legacy_disk_op_translator
